// ===== verilog/stp_map.svh
// Register offsets, field positions and reset values of the timer
`ifndef STP_MAP_SVH
`define STP_MAP_SVH
`define STP_ADR_CTRL   8'h00
`define STP_ADR_CLO    8'h04
`define STP_ADR_CHI    8'h08
`define STP_ADR_STAT   8'h0c
`define STP_ADR_ICLR   8'h10
`define STP_ADR_IEN    8'h14
`define STP_CTRL_ON    0
`define STP_CTRL_PS    1
`define STP_CTRL_ASYNC 3
`define STP_CTRL_EXT   4
`define STP_CTRL_WIDE  5
`define STP_ST_OVF     0
`define STP_CNT_MAX    16'hffff
`define STP_CNT_RST    16'h0000
`define STP_HB_RST     8'h00
`define STP_RD_RST     8'h00
`define STP_PS_RST     3'h0
`define STP_BIT_RST    1'b0
`define STP_PS_W       3
`endif

// ===== verilog/stp_pkg.sv
// Types shared by the timer modules
package stp_pkg;
   typedef enum logic [1:0] {
      STP_DIV1 = 2'b00,
      STP_DIV2 = 2'b01,
      STP_DIV4 = 2'b10,
      STP_DIV8 = 2'b11
   } stp_ps_sel_t;
   typedef struct packed {
      logic        on;
      stp_ps_sel_t ps;
      logic        async;
      logic        ext;
      logic        wide;
      logic [15:0] cnt;
      logic [7:0]  hbuf;
      logic        ovf;
      logic        ien;
      logic        ack;
      logic [7:0]  rdat;
      logic        irq;
      logic        wake;
      logic        align;
   } stp_state_t;
endpackage

// ===== verilog/stp_sync3.sv
// Three-stage pin synchroniser with rising edge pulse
`timescale 1ns/1ps
`default_nettype none
module stp_sync3 (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // Pin and edge
   input  wire logic pin_i,
   output var  logic rise_o
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic level;
      logic rise;
   } stp_sync_t;
   stp_sync_t s_q;
   stp_sync_t s_d;
   always_comb begin
      s_d = s_q;
      s_d.s1 = pin_i;
      s_d.s2 = s_q.s1;
      s_d.s3 = s_q.s2;
      s_d.rise = 1'b0;
      if (s_q.s2 == s_q.s3) begin
         s_d.level = s_q.s2;
         s_d.rise = s_q.s2 & ~s_q.level;
      end
      if (rst_i) begin
         s_d = '0;
      end
   end
   always_ff @(posedge clk_i) begin
      s_q <= s_d;
   end
   assign rise_o = s_q.rise;
endmodule // stp_sync3
`default_nettype wire

// ===== verilog/stp_prescaler.sv
// Hidden prescale counter dividing ticks by 1, 2, 4 or 8
`timescale 1ns/1ps
`default_nettype none
`include "stp_map.svh"
module stp_prescaler #(
   parameter int CNT_W = `STP_PS_W
) (
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   // Ticks
   input  wire logic              tick_i,
   input  wire logic              clr_i,
   input  wire stp_pkg::stp_ps_sel_t sel_i,
   output logic                   tick_o
);
   import stp_pkg::*;
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
   } stp_psc_t;
   stp_psc_t         s_q;
   stp_psc_t         s_d;
   logic [CNT_W-1:0] mask;
   logic             full;
   assign mask = (CNT_W'(1) << sel_i) - CNT_W'(1);
   assign full = (s_q.cnt & mask) == mask;
   assign tick_o = tick_i & full & ~clr_i;
   always_comb begin
      s_d = s_q;
      if (clr_i) begin
         s_d.cnt = '0;
      end else if (tick_i) begin
         s_d.cnt = full ? '0 : s_q.cnt + CNT_W'(1);
      end
      if (rst_i) begin
         s_d.cnt = `STP_PS_RST;
      end
   end
   always_ff @(posedge clk_i) begin
      s_q <= s_d;
   end
endmodule // stp_prescaler
`default_nettype wire

// ===== verilog/stp_timer16.sv
// Sixteen-bit prescaled timer with Wishbone register access
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Prescaler divides the timer clock by 1, 2, 4 or 8 per field
// - Prescale counter is never readable or writable by software
// - Unbuffered write of either count byte clears the prescaler
// - Unsynchronised mode counts external edges without phase alignment
// - Asynchronous external counting keeps running and can wake in sleep
// - Mode switches may skip or add one increment
// - Byte reads during asynchronous counting return valid values
// - Atomic wide access only while buffered enable bit is set
// - Buffered high byte accesses go to the high buffer only
// - Buffered low read captures live high byte into the buffer
// - Buffered high read returns the high buffer
// - Buffered low write loads both bytes, high from the buffer
// - Buffered high write keeps the prescaler; low write clears it
`include "stp_map.svh"
module stp_timer16 (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Clock input and power state
   input  wire logic        ext_clk_i,
   input  wire logic        sleep_i,
   // Interrupt and wake
   output logic             irq_o,
   output logic             wake_o
);
   import stp_pkg::*;

   stp_state_t s_q;
   stp_state_t s_d;
   logic       acc;
   logic       wr;
   logic       rd;
   logic       sel_ctrl;
   logic       sel_lo;
   logic       sel_hi;
   logic       sel_stat;
   logic       sel_iclr;
   logic       sel_ien;
   logic       wr_lo;
   logic       wr_hi;
   logic       rd_lo;
   logic       rd_hi;
   logic       clr_ps;
   logic       rise;
   logic       src_tick;
   logic       run;
   logic       ps_in;
   logic       ps_tick;
   logic       ovf_ev;

   // External clock input
   stp_sync3 u_sync (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .pin_i  (ext_clk_i),
      .rise_o (rise)
   );

   // Bus access decode
   always_comb begin
      acc = wb_cyc_i & wb_stb_i & ~s_q.ack;
      wr = acc & wb_we_i & wb_sel_i[0];
      rd = acc & ~wb_we_i;
      sel_ctrl = 1'b0;
      sel_lo = 1'b0;
      sel_hi = 1'b0;
      sel_stat = 1'b0;
      sel_iclr = 1'b0;
      sel_ien = 1'b0;
      if (wb_adr_i == `STP_ADR_CTRL) begin
         sel_ctrl = 1'b1;
      end else if (wb_adr_i == `STP_ADR_CLO) begin
         sel_lo = 1'b1;
      end else if (wb_adr_i == `STP_ADR_CHI) begin
         sel_hi = 1'b1;
      end else if (wb_adr_i == `STP_ADR_STAT) begin
         sel_stat = 1'b1;
      end else if (wb_adr_i == `STP_ADR_ICLR) begin
         sel_iclr = 1'b1;
      end else if (wb_adr_i == `STP_ADR_IEN) begin
         sel_ien = 1'b1;
      end
   end

   assign wr_lo = wr & sel_lo;
   assign wr_hi = wr & sel_hi;
   assign rd_lo = rd & sel_lo;
   assign rd_hi = rd & sel_hi;
   // Low write always clears; high write only when unbuffered
   assign clr_ps = wr_lo | (wr_hi & ~s_q.wide);

   // Unsynchronised edges count at once, else one aligned cycle later
   always_comb begin
      src_tick = 1'b1;
      if (s_q.ext) begin
         src_tick = s_q.async ? rise : s_q.align;
      end
   end
   // Sleep stops all but asynchronous external counting
   assign run = s_q.on & (~sleep_i | (s_q.async & s_q.ext));
   assign ps_in = run & src_tick;

   stp_prescaler u_psc (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .tick_i (ps_in),
      .clr_i  (clr_ps),
      .sel_i  (s_q.ps),
      .tick_o (ps_tick)
   );

   assign ovf_ev = ps_tick & (s_q.cnt == `STP_CNT_MAX);

   // Next state
   always_comb begin
      s_d = s_q;
      s_d.ack = acc;
      s_d.align = rise;
      if (ps_tick) begin
         s_d.cnt = s_q.cnt + 16'h0001;
      end
      if (wr & sel_ctrl) begin
         s_d.on = wb_dat_i[`STP_CTRL_ON];
         s_d.ps = stp_ps_sel_t'(wb_dat_i[`STP_CTRL_PS +: 2]);
         s_d.async = wb_dat_i[`STP_CTRL_ASYNC];
         s_d.ext = wb_dat_i[`STP_CTRL_EXT];
         s_d.wide = wb_dat_i[`STP_CTRL_WIDE];
      end
      if (wr_lo) begin
         if (s_q.wide) begin
            s_d.cnt = {s_q.hbuf, wb_dat_i[7:0]};
         end else begin
            s_d.cnt[7:0] = wb_dat_i[7:0];
         end
      end
      if (wr_hi) begin
         if (s_q.wide) begin
            s_d.hbuf = wb_dat_i[7:0];
         end else begin
            s_d.cnt[15:8] = wb_dat_i[7:0];
         end
      end
      if (wr & sel_ien) begin
         s_d.ien = wb_dat_i[`STP_ST_OVF];
      end
      if (wr & sel_iclr & wb_dat_i[`STP_ST_OVF]) begin
         s_d.ovf = 1'b0;
      end
      if (ovf_ev) begin
         s_d.ovf = 1'b1;
      end
      if (rd) begin
         s_d.rdat = 8'h00;
         if (sel_ctrl) begin
            s_d.rdat = {2'b00, s_q.wide, s_q.ext, s_q.async, s_q.ps,
                        s_q.on};
         end else if (sel_lo) begin
            s_d.rdat = s_q.cnt[7:0];
            if (s_q.wide) begin
               s_d.hbuf = s_q.cnt[15:8];
            end
         end else if (sel_hi) begin
            s_d.rdat = s_q.wide ? s_q.hbuf : s_q.cnt[15:8];
         end else if (sel_stat) begin
            s_d.rdat = {7'h00, s_q.ovf};
         end else if (sel_ien) begin
            s_d.rdat = {7'h00, s_q.ien};
         end
      end
      s_d.irq = s_d.ovf & s_d.ien;
      s_d.wake = s_d.irq & sleep_i;
      if (rst_i) begin
         s_d.on = `STP_BIT_RST;
         s_d.ps = STP_DIV1;
         s_d.async = `STP_BIT_RST;
         s_d.ext = `STP_BIT_RST;
         s_d.wide = `STP_BIT_RST;
         s_d.cnt = `STP_CNT_RST;
         s_d.hbuf = `STP_HB_RST;
         s_d.ovf = `STP_BIT_RST;
         s_d.ien = `STP_BIT_RST;
         s_d.ack = `STP_BIT_RST;
         s_d.rdat = `STP_RD_RST;
         s_d.irq = `STP_BIT_RST;
         s_d.wake = `STP_BIT_RST;
         s_d.align = `STP_BIT_RST;
      end
   end

   always_ff @(posedge clk_i) begin
      s_q <= s_d;
   end

   assign wb_dat_o = {24'h000000, s_q.rdat};
   assign wb_ack_o = s_q.ack;
   assign irq_o = s_q.irq;
   assign wake_o = s_q.wake;

   // Checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   property p_ps_div8;
      (ps_tick && s_q.ps == STP_DIV8) |=>
         (!ps_tick || s_q.ps != STP_DIV8) [*7];
   endproperty
   a_ps_div8: assert property (p_ps_div8)
      else $error("divide by eight ticked early");

   property p_ps_clear;
      (wr_hi && !s_q.wide) |=> (u_psc.s_q.cnt == 3'h0);
   endproperty
   a_ps_clear: assert property (p_ps_clear)
      else $error("prescaler not cleared on byte write");

   property p_hi_keep_ps;
      (wr_hi && s_q.wide && !ps_in) |=>
         (u_psc.s_q.cnt == $past(u_psc.s_q.cnt));
   endproperty
   a_hi_keep_ps: assert property (p_hi_keep_ps)
      else $error("buffered high write touched prescaler");

   property p_async_now;
      (rise && s_q.on && s_q.ext && s_q.async) |-> ps_in;
   endproperty
   a_async_now: assert property (p_async_now)
      else $error("asynchronous edge not counted at once");

   property p_sync_late;
      (rise && s_q.on && s_q.ext && !s_q.async && !sleep_i) ##1
         (s_q.on && s_q.ext && !s_q.async && !sleep_i) |-> ps_in;
   endproperty
   a_sync_late: assert property (p_sync_late)
      else $error("synchronous edge not counted one cycle later");

   property p_sleep_run;
      (sleep_i && s_q.on && !(s_q.ext && s_q.async)) |-> !ps_in;
   endproperty
   a_sleep_run: assert property (p_sleep_run)
      else $error("timer ran in sleep outside asynchronous mode");

   property p_lo_capture;
      (rd_lo && s_q.wide) |=> (s_q.hbuf == $past(s_q.cnt[15:8]));
   endproperty
   a_lo_capture: assert property (p_lo_capture)
      else $error("low read did not capture high byte");

   property p_hi_read;
      (rd_hi && s_q.wide) |=> (wb_dat_o[7:0] == $past(s_q.hbuf));
   endproperty
   a_hi_read: assert property (p_hi_read)
      else $error("buffered high read not from buffer");

   property p_lo_write;
      (wr_lo && s_q.wide) |=>
         (s_q.cnt == {$past(s_q.hbuf), $past(wb_dat_i[7:0])});
   endproperty
   a_lo_write: assert property (p_lo_write)
      else $error("buffered low write did not load both bytes");

   property p_hi_write;
      (wr_hi && s_q.wide) |=>
         (s_q.hbuf == $past(wb_dat_i[7:0])) &&
         (s_q.cnt == $past(s_q.cnt) + {15'h0000, $past(ps_tick)});
   endproperty
   a_hi_write: assert property (p_hi_write)
      else $error("buffered high write reached live byte");

   property p_wrap;
      (ps_tick && s_q.cnt == 16'hffff && !wr_lo && !wr_hi) |=>
         (s_q.cnt == 16'h0000 && s_q.ovf && irq_o == s_q.ien);
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("wrap did not set overflow");

   property p_reset;
      @(posedge clk_i) disable iff (1'b0)
         rst_i |=> (s_q.cnt == 16'h0000 && s_q.hbuf == 8'h00 &&
                    !s_q.on && !s_q.wide && !irq_o && !wb_ack_o);
   endproperty
   a_reset: assert property (p_reset)
      else $error("reset left state set");

   property p_ack_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("ack held more than one cycle");

   property p_ack_next;
      acc |=> wb_ack_o;
   endproperty
   a_ack_next: assert property (p_ack_next)
      else $error("request not acknowledged next cycle");

   property p_lo_clear_ps;
      wr_lo |=> (u_psc.s_q.cnt == 3'h0);
   endproperty
   a_lo_clear_ps: assert property (p_lo_clear_ps)
      else $error("low write did not clear prescaler");

   property p_unbuf_hi;
      (wr_hi && !s_q.wide) |=> (s_q.cnt[15:8] == $past(wb_dat_i[7:0]));
   endproperty
   a_unbuf_hi: assert property (p_unbuf_hi)
      else $error("unbuffered high write missed live byte");

   property p_hbuf_idle;
      !s_q.wide |=> $stable(s_q.hbuf);
   endproperty
   a_hbuf_idle: assert property (p_hbuf_idle)
      else $error("high buffer moved outside buffered mode");

   property p_ovf_sticky;
      (ovf_ev || (s_q.ovf && !(wr && sel_iclr && wb_dat_i[`STP_ST_OVF])))
         |=> s_q.ovf;
   endproperty
   a_ovf_sticky: assert property (p_ovf_sticky)
      else $error("overflow flag lost without clear");

   property p_wake;
      wake_o == (irq_o && $past(sleep_i));
   endproperty
   a_wake: assert property (p_wake)
      else $error("wake not tied to interrupt in sleep");

   c_wrap: cover property (ovf_ev);
   c_wide_pair: cover property (rd_lo && s_q.wide ##[1:20] rd_hi);
   c_sleep_wake: cover property (sleep_i && ovf_ev ##[1:3] wake_o);
   c_sync_count: cover property (rise && s_q.ext && !s_q.async ##1 ps_in);
endmodule // stp_timer16
`default_nettype wire

// ===== testbench/stp_ext_src.sv
// External clock source model driving the timer count pin
`timescale 1ns/1ps
`default_nettype none
module stp_ext_src (
   // Clock
   input  wire logic       clk_i,
   // Control
   input  wire logic       run_i,
   input  wire logic [3:0] half_i,
   // Pin
   output logic            ext_o
);
   logic [3:0] cnt_q;
   initial begin
      cnt_q = 4'h0;
      ext_o = 1'b0;
   end
   // Pin rests low between bursts
   always @(posedge clk_i) begin
      if (!run_i) begin
         cnt_q <= 4'h0;
         ext_o <= 1'b0;
      end else if (cnt_q == half_i) begin
         cnt_q <= 4'h0;
         ext_o <= ~ext_o;
      end else begin
         cnt_q <= cnt_q + 4'h1;
      end
   end
endmodule // stp_ext_src
`default_nettype wire

// ===== testbench/tb.sv
// Self-checking bench for the sixteen-bit prescaled timer
`timescale 1ns/1ps
`default_nettype none
`include "stp_map.svh"
module tb;
   localparam logic [7:0] a_ct = `STP_ADR_CTRL;
   localparam logic [7:0] a_lo = `STP_ADR_CLO;
   localparam logic [7:0] a_hi = `STP_ADR_CHI;
   localparam logic [7:0] a_st = `STP_ADR_STAT;
   localparam logic [7:0] a_ic = `STP_ADR_ICLR;
   localparam logic [7:0] a_ie = `STP_ADR_IEN;
   logic        clk_i;
   logic        rst_i;
   logic        wb_cyc;
   logic        wb_stb;
   logic        wb_we;
   logic [7:0]  wb_adr;
   logic [3:0]  wb_sel;
   logic [31:0] wb_dat_w;
   logic [31:0] wb_dat_r;
   logic        wb_ack;
   logic        ext_clk;
   logic        ext_run;
   logic        sleep;
   logic        irq;
   logic        wake;
   logic [7:0]  rd;
   int          bad_count;
   int          checks;

   stp_timer16 dut (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .wb_cyc_i  (wb_cyc),
      .wb_stb_i  (wb_stb),
      .wb_we_i   (wb_we),
      .wb_adr_i  (wb_adr),
      .wb_sel_i  (wb_sel),
      .wb_dat_i  (wb_dat_w),
      .wb_dat_o  (wb_dat_r),
      .wb_ack_o  (wb_ack),
      .ext_clk_i (ext_clk),
      .sleep_i   (sleep),
      .irq_o     (irq),
      .wake_o    (wake)
   );

   stp_ext_src src (
      .clk_i  (clk_i),
      .run_i  (ext_run),
      .half_i (4'h3),
      .ext_o  (ext_clk)
   );

   task automatic bad(input string m);
      bad_count++;
      $display("BAD %0t %s", $time, m);
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         bad($sformatf("got %h want %h", got, exp));
      end
   endtask

   // One classic cycle; waits for ack, then idles a cycle
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      wb_cyc   <= 1'b1;
      wb_stb   <= 1'b1;
      wb_we    <= w;
      wb_sel   <= 4'hf;
      wb_adr   <= a;
      wb_dat_w <= {24'h0, d};
      @(posedge clk_i);
      while (wb_ack !== 1'b1 && n < 20) begin
         @(posedge clk_i);
         n++;
      end
      if (n == 20) begin
         bad("no ack");
      end
      rd = wb_dat_r[7:0];
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we  <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      wb(1'b1, a, d);
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      wb(1'b0, a, 8'h00);
      chk(rd, e);
   endtask

   task automatic t_reset();
      rchk(a_ct, 8'h00);
      rchk(a_lo, 8'h00);
      rchk(a_hi, 8'h00);
      rchk(a_st, 8'h00);
      rchk(a_ie, 8'h00);
      rchk(a_ic, 8'h00);
      rchk(8'h18, 8'h00);
   endtask

   // Run 64 cycles at each ratio
   task automatic t_prescale();
      for (int s = 0; s < 4; s++) begin
         wr(a_hi, 8'h00);
         wr(a_lo, 8'h00);
         wr(a_ct, {5'h00, 2'(s), 1'b1});
         repeat (61) @(posedge clk_i);
         wr(a_ct, 8'h00);
         rchk(a_lo, 8'(64 >> s));
      end
   endtask

   // High byte writes closer than the ratio keep the count still
   task automatic t_clear();
      wr(a_lo, 8'h00);
      wr(a_ct, 8'h07);
      repeat (6) wr(a_hi, 8'h00);
      wr(a_ct, 8'h00);
      rchk(a_lo, 8'h00);
   endtask

   task automatic t_wide();
      wr(a_ct, 8'h20);
      wr(a_hi, 8'h12);
      rchk(a_hi, 8'h12);
      wr(a_lo, 8'h34);
      wr(a_hi, 8'h56);
      wr(a_ct, 8'h00);
      rchk(a_hi, 8'h12);
      rchk(a_lo, 8'h34);
      wr(a_ct, 8'h20);
      rchk(a_hi, 8'h56);
      rchk(a_lo, 8'h34);
      rchk(a_hi, 8'h12);
      wr(a_ct, 8'h00);
      wr(a_hi, 8'h77);
      rchk(a_hi, 8'h77);
      wr(a_ct, 8'h27);
      wr(a_lo, 8'h00);
      repeat (10) wr(a_hi, 8'h00);
      wr(a_ct, 8'h20);
      wb(1'b0, a_lo, 8'h00);
      checks++;
      if ((rd >= 8'h03 && rd <= 8'h05) !== 1'b1) begin
         bad("high write cleared prescaler");
      end
      wr(a_ct, 8'h00);
   endtask

   task automatic t_irq();
      wr(a_ct, 8'h00);
      wr(a_hi, 8'hff);
      wr(a_lo, 8'hf8);
      wr(a_ct, 8'h01);
      repeat (20) @(posedge clk_i);
      chk({7'h00, irq}, 8'h00);
      rchk(a_st, 8'h01);
      rchk(a_hi, 8'h00);
      wr(a_ie, 8'h01);
      @(posedge clk_i);
      chk({7'h00, irq}, 8'h01);
      wr(a_ic, 8'h01);
      @(posedge clk_i);
      chk({7'h00, irq}, 8'h00);
      rchk(a_st, 8'h00);
      wr(a_ct, 8'h00);
   endtask

   task automatic t_async();
      int n;
      n = 0;
      wr(a_hi, 8'hff);
      wr(a_lo, 8'hfc);
      wr(a_ct, 8'h19);
      sleep   <= 1'b1;
      ext_run <= 1'b1;
      while (wake !== 1'b1 && n < 200) begin
         @(posedge clk_i);
         n++;
      end
      chk({7'h00, wake}, 8'h01);
      sleep <= 1'b0;
      rchk(a_hi, 8'h00);
      ext_run <= 1'b0;
      repeat (8) @(posedge clk_i);
      wr(a_ct, 8'h00);
      wr(a_lo, 8'h00);
      wr(a_ct, 8'h11);
      ext_run <= 1'b1;
      repeat (40) @(posedge clk_i);
      ext_run <= 1'b0;
      repeat (8) @(posedge clk_i);
      wr(a_ct, 8'h00);
      rchk(a_lo, 8'h05);
      wr(a_ct, 8'h11);
      sleep   <= 1'b1;
      ext_run <= 1'b1;
      repeat (100) @(posedge clk_i);
      ext_run <= 1'b0;
      repeat (10) @(posedge clk_i);
      sleep <= 1'b0;
      rchk(a_lo, 8'h05);
      wr(a_ct, 8'h00);
      wr(a_ic, 8'h01);
   endtask

   // Mid-run reset with live state
   task automatic t_rerst();
      wr(a_ie, 8'h01);
      wr(a_hi, 8'h5a);
      wr(a_ct, 8'h27);
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset();
   endtask

   task automatic finish_test();
      if (bad_count == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   initial begin
      repeat (20000) @(posedge clk_i);
      bad("watchdog");
      finish_test();
   end

   initial begin
      bad_count = 0;
      checks    = 0;
      rst_i     = 1'b1;
      wb_cyc    = 1'b0;
      wb_stb    = 1'b0;
      wb_we     = 1'b0;
      wb_adr    = 8'h00;
      wb_sel    = 4'hf;
      wb_dat_w  = 32'h0;
      ext_run   = 1'b0;
      sleep     = 1'b0;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset();
      t_prescale();
      t_clear();
      t_wide();
      t_irq();
      t_async();
      t_rerst();
      finish_test();
   end
endmodule // tb
`default_nettype wire
